// [design/mab_bank.sv]
// Medium-access management attribute bank with the timers its attributes steer.
// Assumes requests and node events come from logic on clk; node role and robust
// mode arrive on pins and are synchronised here.
//
// Contract
// - Smoothed statistics follow new/2^S plus previous weighted by the rest; S 0-7, default 3.
// - Segment code limits data request length; 0 unrestricted, 4 is 64, 7 is 255 bytes.
// - Segment size and forced modulation are writable only in a base node.
// - Forced modulation codes 0 automatic, 1-3 single modulations; default 0.
// - At most the configured maximum promotion requests per rate period.
// - Disconnected node scans for the switch search time before any promotion request.
// - CSMA retries busy-channel attempts up to the configured count, 2-5, default 5.
// - Control packet retransmission allowed only after the retransmit timer expires unacknowledged.
// - Child transaction declared expired after the configured failure time.
// - Disconnected node moves to another band after the band search time.
// - At most one promotion request within each minimum promotion period.
// - Legacy devices send at least one promotion request per maximum period.
// - Channel senses spaced by 3 ms normally, 6 ms in robust mode.
// - Exponential contention factor 3 normally, 4 in robust mode.
// - Alive-time mode selects version mapping 0 or compatible mapping 1.
// - Keep-alive packets repeated per hop the configured count, default 5.
// - Attributes are read and written by identifier at any time after start-up.
// - Version and channel-sense count cannot be changed by set requests.
`timescale 1ns/1ps
`default_nettype none
module mab_bank
  import mab_pkg::*;
#(
  parameter int SEC_CYCLES = MAB_SEC_CYCLES,
  parameter int MS_CYCLES = MAB_MS_CYCLES,
  parameter logic [7:0] VERSION_CODE = 8'h5A, // Arbitrary value
  parameter logic [7:0] SENSE_COUNT = 8'h05,
  parameter logic ALIVE_MODE = 1'b0,
  parameter logic LEGACY = 1'b1
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic base_node_pin,
  input wire logic robust_mode_pin,
  input wire logic [47:0] node_address,
  input wire logic req_valid,
  input wire logic req_set,
  input wire logic [15:0] req_id,
  input wire logic [47:0] req_wdata,
  output logic rsp_valid,
  output logic [1:0] rsp_status,
  output logic [47:0] rsp_rdata,
  input wire logic stat_valid,
  input wire logic [15:0] stat_sample,
  output logic [15:0] stat_avg,
  input wire logic disconnected,
  input wire logic promo_req,
  output logic promo_grant,
  output logic promo_due,
  output logic band_move,
  input wire logic ctl_sent,
  input wire logic ctl_ack,
  output logic ctl_retx_ok,
  input wire logic child_txn_start,
  input wire logic child_txn_done,
  output logic child_txn_expired,
  input wire logic data_len_valid,
  input wire logic [15:0] data_len,
  output logic data_len_ok,
  output logic [1:0] forced_mod,
  output logic [2:0] csma_attempts,
  output logic [2:0] ka_repeats,
  output logic alive_map,
  output logic [3:0] cw_exp,
  output logic [3:0] cw_lin,
  output logic [23:0] sense_gap_cycles,
  output logic [15:0] route_timeout
);
  localparam logic [31:0] SEC_LAST = 32'(SEC_CYCLES - 1);

  // Pin synchronisers
  logic base_s1_r, base_s2_r, rob_s1_r, rob_s2_r;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      base_s1_r <= 1'b0;
      base_s2_r <= 1'b0;
      rob_s1_r <= 1'b0;
      rob_s2_r <= 1'b0;
    end
    else
    begin
      base_s1_r <= base_node_pin;
      base_s2_r <= base_s1_r;
      rob_s1_r <= robust_mode_pin;
      rob_s2_r <= rob_s1_r;
    end
  end
  wire is_base = base_s2_r;
  wire is_robust = rob_s2_r;

  // Writable attribute slots
  logic [7:0] rw_r [MAB_RW_N];
  logic [MAB_RW_N-1:0] slot_hit;
  logic [MAB_RW_N-1:0] slot_ok;
  logic [MAB_RW_N-1:0] slot_lock;
  logic [7:0] slot_term [MAB_RW_N];
  wire wide_zero = (req_wdata[47:8] == 40'h0);
  wire set_req = req_valid && req_set;

  genvar gi;
  generate
    for (gi = 0; gi < MAB_RW_N; gi++)
    begin : g_slot
      assign slot_hit[gi] = req_valid && (req_id == MAB_RW_ID[gi]);
      assign slot_ok[gi] = wide_zero && (req_wdata[7:0] >= MAB_RW_MIN[gi])
                           && (req_wdata[7:0] <= MAB_RW_MAX[gi]);
      assign slot_lock[gi] = MAB_RW_BASE_ONLY[gi] && !is_base;
      assign slot_term[gi] = slot_hit[gi] ? rw_r[gi] : 8'h00;
      always_ff @(posedge clk or negedge arst_n)
      begin
        if (!arst_n)
          rw_r[gi] <= MAB_RW_RST[gi];
        else if (set_req && slot_hit[gi] && slot_ok[gi] && !slot_lock[gi])
          rw_r[gi] <= req_wdata[7:0];
      end
    end
  endgenerate

  logic [7:0] rw_rdata;
  always_comb
  begin
    rw_rdata = 8'h00;
    for (int i = 0; i < MAB_RW_N; i++)
      rw_rdata = rw_rdata | slot_term[i];
  end

  // Route entry timeout, the one sixteen-bit writable attribute
  logic [15:0] route_r;
  wire route_hit = req_valid && (req_id == MAB_ID_ROUTE_TIMEOUT);
  wire route_ok = (req_wdata[47:16] == 32'h0) && (req_wdata[15:0] >= MAB_ROUTE_MIN)
                  && (req_wdata[15:0] <= MAB_ROUTE_MAX);
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      route_r <= MAB_ROUTE_RST;
    else if (set_req && route_hit && route_ok)
      route_r <= req_wdata[15:0];
  end

  // Read-only attributes
  wire [7:0] cw_exp_v = is_robust ? MAB_CW_EXP_ROB_VAL : MAB_CW_EXP_VAL;
  wire [7:0] cw_lin_v = is_robust ? MAB_CW_LIN_ROB_VAL : MAB_CW_LIN_VAL;
  wire [7:0] delay_ms = is_robust ? MAB_SENSE_DELAY_ROB_MS : MAB_SENSE_DELAY_MS;
  wire ro_hit = req_valid && (req_id == MAB_ID_VERSION || req_id == MAB_ID_SENSE_COUNT
                || req_id == MAB_ID_HW_ADDR || req_id == MAB_ID_CW_EXP || req_id == MAB_ID_CW_LIN
                || req_id == MAB_ID_SENSE_DELAY || req_id == MAB_ID_CW_EXP_ROB
                || req_id == MAB_ID_CW_LIN_ROB || req_id == MAB_ID_SENSE_DELAY_ROB
                || req_id == MAB_ID_ALIVE_MAP);
  wire [47:0] ro_rdata =
    (req_id == MAB_ID_VERSION) ? {40'h0, VERSION_CODE} :
    (req_id == MAB_ID_SENSE_COUNT) ? {40'h0, SENSE_COUNT} :
    (req_id == MAB_ID_HW_ADDR) ? node_address :
    (req_id == MAB_ID_CW_EXP) ? {40'h0, MAB_CW_EXP_VAL} :
    (req_id == MAB_ID_CW_LIN) ? {40'h0, MAB_CW_LIN_VAL} :
    (req_id == MAB_ID_SENSE_DELAY) ? {40'h0, MAB_SENSE_DELAY_MS} :
    (req_id == MAB_ID_CW_EXP_ROB) ? {40'h0, MAB_CW_EXP_ROB_VAL} :
    (req_id == MAB_ID_CW_LIN_ROB) ? {40'h0, MAB_CW_LIN_ROB_VAL} :
    (req_id == MAB_ID_SENSE_DELAY_ROB) ? {40'h0, MAB_SENSE_DELAY_ROB_MS} :
    (req_id == MAB_ID_ALIVE_MAP) ? {47'h0, ALIVE_MODE} : 48'h0;

  // Answer decode
  wire any_rw_hit = |slot_hit;
  wire rw_refused = |(slot_hit & (~slot_ok | slot_lock));
  wire rw_ro = |(slot_hit & slot_lock);
  wire [1:0] status_nxt =
    (!any_rw_hit && !route_hit && !ro_hit) ? MAB_ST_UNKNOWN :
    !req_set ? MAB_ST_OK :
    (ro_hit || rw_ro) ? MAB_ST_READ_ONLY :
    ((any_rw_hit && rw_refused) || (route_hit && !route_ok)) ? MAB_ST_RANGE :
    MAB_ST_OK;
  wire [47:0] rdata_nxt = req_set ? 48'h0 :
    any_rw_hit ? {40'h0, rw_rdata} :
    route_hit ? {32'h0, route_r} : ro_rdata;

  logic rsp_valid_r;
  logic [1:0] rsp_status_r;
  logic [47:0] rsp_rdata_r;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      rsp_valid_r <= 1'b0;
      rsp_status_r <= MAB_ST_OK;
      rsp_rdata_r <= 48'h0;
    end
    else
    begin
      rsp_valid_r <= req_valid;
      if (req_valid)
      begin
        rsp_status_r <= status_nxt;
        rsp_rdata_r <= rdata_nxt;
      end
    end
  end

  // Statistic smoothing
  mab_ema #(.W(16)) u_ema (
    .clk(clk),
    .arst_n(arst_n),
    .sample_valid(stat_valid),
    .sample(stat_sample),
    .shift(rw_r[MAB_S_EMA_SHIFT][2:0]),
    .avg(stat_avg)
  );

  // One-second enable
  logic [31:0] sec_cnt_r;
  logic tick;
  assign tick = (sec_cnt_r == SEC_LAST);
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      sec_cnt_r <= 32'h0;
    else
      sec_cnt_r <= tick ? 32'h0 : sec_cnt_r + 32'h1;
  end

  // Promotion request pacing
  logic [7:0] search_r, win_r, gap_r, maxp_r, band_r;
  logic [2:0] sent_r;
  logic promo_grant_r, promo_due_r, band_move_r;
  wire svc_disc = disconnected && !is_base;
  wire search_done = search_r > rw_r[MAB_S_SWITCH_SEARCH];
  wire gap_ok = gap_r > rw_r[MAB_S_PROMO_MIN];
  wire quota_ok = {5'h0, sent_r} < rw_r[MAB_S_MAX_PROMO];
  wire grant_nxt = promo_req && svc_disc && search_done && gap_ok && quota_ok;
  wire win_end = tick && ((win_r + 8'h1) >= rw_r[MAB_S_RATE_PERIOD]);
  wire maxp_end = LEGACY && svc_disc && tick && ((maxp_r + 8'h1) >= rw_r[MAB_S_PROMO_MAX]);
  wire band_end = disconnected && tick && ((band_r + 8'h1) >= rw_r[MAB_S_BAND_SEARCH]);

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      search_r <= 8'h00;
      win_r <= 8'h00;
      sent_r <= 3'h0;
      gap_r <= MAB_SEC_SAT;
      maxp_r <= 8'h00;
      band_r <= 8'h00;
      promo_grant_r <= 1'b0;
      promo_due_r <= 1'b0;
      band_move_r <= 1'b0;
    end
    else
    begin
      promo_grant_r <= grant_nxt;
      if (!disconnected)
        search_r <= 8'h00;
      else if (tick && search_r != MAB_SEC_SAT)
        search_r <= search_r + 8'h1;
      win_r <= win_end ? 8'h00 : (tick ? win_r + 8'h1 : win_r);
      if (win_end)
        sent_r <= {2'h0, grant_nxt};
      else if (grant_nxt)
        sent_r <= sent_r + 3'h1;
      if (grant_nxt)
        gap_r <= 8'h00;
      else if (tick && gap_r != MAB_SEC_SAT)
        gap_r <= gap_r + 8'h1;
      // Legacy keep-up: demand a request when the longest period runs out
      promo_due_r <= maxp_end;
      if (!svc_disc || grant_nxt || maxp_end)
        maxp_r <= 8'h00;
      else if (tick)
        maxp_r <= maxp_r + 8'h1;
      band_move_r <= band_end;
      if (!disconnected || band_end)
        band_r <= 8'h00;
      else if (tick)
        band_r <= band_r + 8'h1;
    end
  end

  // Control packet retransmit wait; a new send wins over an acknowledgement
  logic ctl_wait_r, ctl_retx_r;
  logic [7:0] ctl_cnt_r;
  wire ctl_expire = ctl_wait_r && tick && (({1'b0, ctl_cnt_r} + 9'h001) > {1'b0, rw_r[MAB_S_RETX_TIMER]});
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      ctl_wait_r <= 1'b0;
      ctl_retx_r <= 1'b0;
      ctl_cnt_r <= 8'h00;
    end
    else if (ctl_sent)
    begin
      ctl_wait_r <= 1'b1;
      ctl_retx_r <= 1'b0;
      ctl_cnt_r <= 8'h00;
    end
    else if (ctl_ack)
    begin
      ctl_wait_r <= 1'b0;
      ctl_retx_r <= 1'b0;
    end
    else if (ctl_expire)
    begin
      ctl_wait_r <= 1'b0;
      ctl_retx_r <= 1'b1;
    end
    else if (ctl_wait_r && tick)
      ctl_cnt_r <= ctl_cnt_r + 8'h1;
  end

  // Child transaction failure timer
  logic child_busy_r, child_exp_r;
  logic [7:0] child_cnt_r;
  wire child_end = child_busy_r && tick && ((child_cnt_r + 8'h1) >= rw_r[MAB_S_FAIL_TIME]);
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      child_busy_r <= 1'b0;
      child_exp_r <= 1'b0;
      child_cnt_r <= 8'h00;
    end
    else
    begin
      child_exp_r <= child_end && !child_txn_start && !child_txn_done;
      if (child_txn_start)
      begin
        child_busy_r <= 1'b1;
        child_cnt_r <= 8'h00;
      end
      else if (child_txn_done || child_end)
        child_busy_r <= 1'b0;
      else if (child_busy_r && tick)
        child_cnt_r <= child_cnt_r + 8'h1;
    end
  end

  // Data request length check and exported settings
  wire [2:0] seg_code = rw_r[MAB_S_SEGMENT][2:0];
  wire len_ok_nxt = (seg_code == 3'h0) || (data_len <= {8'h00, MAB_SEG_BYTES[seg_code]});
  logic data_len_ok_r;
  logic [23:0] gap_cycles_r;
  logic [3:0] cw_exp_r, cw_lin_r;
  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
    begin
      data_len_ok_r <= 1'b0;
      gap_cycles_r <= 24'h0;
      cw_exp_r <= 4'h0;
      cw_lin_r <= 4'h0;
    end
    else
    begin
      if (data_len_valid)
        data_len_ok_r <= len_ok_nxt;
      gap_cycles_r <= 24'(32'(delay_ms) * 32'(MS_CYCLES));
      cw_exp_r <= cw_exp_v[3:0];
      cw_lin_r <= cw_lin_v[3:0];
    end
  end

  assign rsp_valid = rsp_valid_r;
  assign rsp_status = rsp_status_r;
  assign rsp_rdata = rsp_rdata_r;
  assign promo_grant = promo_grant_r;
  assign promo_due = promo_due_r;
  assign band_move = band_move_r;
  assign ctl_retx_ok = ctl_retx_r;
  assign child_txn_expired = child_exp_r;
  assign data_len_ok = data_len_ok_r;
  assign forced_mod = rw_r[MAB_S_FORCED_MOD][1:0];
  assign csma_attempts = rw_r[MAB_S_CSMA_ATTEMPTS][2:0];
  assign ka_repeats = rw_r[MAB_S_KA_REPEATS][2:0];
  assign alive_map = ALIVE_MODE;
  assign cw_exp = cw_exp_r;
  assign cw_lin = cw_lin_r;
  assign sense_gap_cycles = gap_cycles_r;
  assign route_timeout = route_r;
endmodule // mab_bank
`default_nettype wire

// [include/mab_pkg.sv]
// Constants for the management attribute bank: identifiers, ranges, resets, timing.
// Assumes a single 40 MHz clock domain.
`default_nettype none
package mab_pkg;

  // Clock and time bases
  localparam int MAB_CLK_HZ = 40000000;
  localparam int MAB_SECOND_S = 1;
  localparam int MAB_SEC_CYCLES = MAB_CLK_HZ * MAB_SECOND_S;
  localparam int MAB_MS_CYCLES = MAB_CLK_HZ / 1000;

  // Answer status codes
  localparam logic [1:0] MAB_ST_OK = 2'h0;
  localparam logic [1:0] MAB_ST_UNKNOWN = 2'h1;
  localparam logic [1:0] MAB_ST_READ_ONLY = 2'h2;
  localparam logic [1:0] MAB_ST_RANGE = 2'h3;

  // Writable 8-bit attribute slots
  localparam int MAB_RW_N = 13;
  localparam int MAB_S_SWITCH_SEARCH = 0;
  localparam int MAB_S_MAX_PROMO = 1;
  localparam int MAB_S_RATE_PERIOD = 2;
  localparam int MAB_S_CSMA_ATTEMPTS = 3;
  localparam int MAB_S_RETX_TIMER = 4;
  localparam int MAB_S_FAIL_TIME = 5;
  localparam int MAB_S_EMA_SHIFT = 6;
  localparam int MAB_S_BAND_SEARCH = 7;
  localparam int MAB_S_PROMO_MAX = 8;
  localparam int MAB_S_PROMO_MIN = 9;
  localparam int MAB_S_SEGMENT = 10;
  localparam int MAB_S_FORCED_MOD = 11;
  localparam int MAB_S_KA_REPEATS = 12;

  localparam logic [15:0] MAB_RW_ID [MAB_RW_N] = '{
    16'h0010, 16'h0011, 16'h0012, 16'h0014, 16'h0015, 16'h0018, 16'h0019,
    16'h001A, 16'h001B, 16'h001C, 16'h001D, 16'h004A, 16'h004C};
  localparam logic [7:0] MAB_RW_MIN [MAB_RW_N] = '{
    8'h10, 8'h01, 8'h02, 8'h02, 8'h02, 8'h06, 8'h00,
    8'h20, 8'h10, 8'h02, 8'h00, 8'h00, 8'h00};
  localparam logic [7:0] MAB_RW_MAX [MAB_RW_N] = '{
    8'h20, 8'h04, 8'h08, 8'h05, 8'hFF, 8'h64, 8'h07,
    8'h78, 8'h78, 8'h10, 8'h07, 8'h03, 8'h07};
  localparam logic [7:0] MAB_RW_RST [MAB_RW_N] = '{
    8'h18, 8'h02, 8'h05, 8'h05, 8'h02, 8'h2D, 8'h03,
    8'h3C, 8'h20, 8'h02, 8'h00, 8'h00, 8'h05};
  localparam logic [MAB_RW_N-1:0] MAB_RW_BASE_ONLY = 13'h0C00;

  // Sixteen-bit route entry timeout
  localparam logic [15:0] MAB_ID_ROUTE_TIMEOUT = 16'h004B;
  localparam logic [15:0] MAB_ROUTE_MIN = 16'h003C;
  localparam logic [15:0] MAB_ROUTE_MAX = 16'h0E10;
  localparam logic [15:0] MAB_ROUTE_RST = 16'h00F0;

  // Read-only attributes
  localparam logic [15:0] MAB_ID_VERSION = 16'h0001;
  localparam logic [15:0] MAB_ID_SENSE_COUNT = 16'h0017;
  localparam logic [15:0] MAB_ID_HW_ADDR = 16'h001F;
  localparam logic [15:0] MAB_ID_CW_EXP = 16'h0034;
  localparam logic [15:0] MAB_ID_CW_LIN = 16'h0035;
  localparam logic [15:0] MAB_ID_SENSE_DELAY = 16'h0038;
  localparam logic [15:0] MAB_ID_CW_EXP_ROB = 16'h003B;
  localparam logic [15:0] MAB_ID_CW_LIN_ROB = 16'h003C;
  localparam logic [15:0] MAB_ID_SENSE_DELAY_ROB = 16'h003D;
  localparam logic [15:0] MAB_ID_ALIVE_MAP = 16'h003E;

  localparam logic [7:0] MAB_CW_EXP_VAL = 8'h03;
  localparam logic [7:0] MAB_CW_LIN_VAL = 8'h01;
  localparam logic [7:0] MAB_SENSE_DELAY_MS = 8'h03;
  localparam logic [7:0] MAB_CW_EXP_ROB_VAL = 8'h04;
  localparam logic [7:0] MAB_CW_LIN_ROB_VAL = 8'h02;
  localparam logic [7:0] MAB_SENSE_DELAY_ROB_MS = 8'h06;

  // Segment size limits in bytes per code, code 0 unrestricted
  localparam logic [7:0] MAB_SEG_BYTES [8] = '{
    8'h00, 8'h10, 8'h20, 8'h30, 8'h40, 8'h80, 8'hC0, 8'hFF};

  localparam logic [7:0] MAB_SEC_SAT = 8'hFF;

endpackage
`default_nettype wire

// [design/mab_ema.sv]
// Exponential moving average of one statistic with a power-of-two smoothing factor.
// Assumes samples arrive as one-cycle strobes on the bank clock.
`timescale 1ns/1ps
`default_nettype none
module mab_ema
#(
  parameter int W = 16
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic sample_valid,
  input wire logic [W-1:0] sample,
  input wire logic [2:0] shift,
  output logic [W-1:0] avg
);
  logic [W-1:0] avg_r;
  logic [W-1:0] avg_nxt;
  logic signed [W:0] diff;
  logic signed [W:0] step;

  // next = prev + (sample - prev) / 2^shift
  assign diff = $signed({1'b0, sample}) - $signed({1'b0, avg_r});
  assign step = diff >>> shift;
  assign avg_nxt = avg_r + step[W-1:0];

  always_ff @(posedge clk or negedge arst_n)
  begin
    if (!arst_n)
      avg_r <= '0;
    else if (sample_valid)
      avg_r <= avg_nxt;
  end

  assign avg = avg_r;
endmodule // mab_ema
`default_nettype wire

// [bench/mab_bank_sva.sv]
// Port checker for the management attribute bank.
// Bound to every mab_bank instance; single clock domain.
`timescale 1ns/1ps
`default_nettype none
module mab_bank_sva
  import mab_pkg::*;
#(
  parameter int MS_CYCLES = MAB_MS_CYCLES
)
(
  input wire logic clk,
  input wire logic arst_n,
  input wire logic [47:0] node_address,
  input wire logic req_valid,
  input wire logic req_set,
  input wire logic [15:0] req_id,
  input wire logic rsp_valid,
  input wire logic [1:0] rsp_status,
  input wire logic [47:0] rsp_rdata,
  input wire logic disconnected,
  input wire logic promo_req,
  input wire logic promo_grant,
  input wire logic ctl_sent,
  input wire logic ctl_retx_ok,
  input wire logic [2:0] csma_attempts,
  input wire logic [3:0] cw_exp,
  input wire logic [3:0] cw_lin,
  input wire logic [23:0] sense_gap_cycles
);
  default clocking @(posedge clk); endclocking
  default disable iff (!arst_n);
  sequence s_set(id);
    req_valid && req_set && req_id == id;
  endsequence
  sequence s_get_addr;
    req_valid && !req_set && req_id == MAB_ID_HW_ADDR;
  endsequence
  property p_answer;
    req_valid |=> rsp_valid;
  endproperty
  a_answer: assert property (p_answer) else $error("no answer after request");
  property p_quiet;
    !req_valid |=> !rsp_valid;
  endproperty
  a_quiet: assert property (p_quiet) else $error("answer without request");
  property p_version_ro;
    s_set(MAB_ID_VERSION) |=> rsp_status == MAB_ST_READ_ONLY;
  endproperty
  a_version_ro: assert property (p_version_ro) else $error("version write not refused");
  property p_count_ro;
    s_set(MAB_ID_SENSE_COUNT) |=> rsp_status == MAB_ST_READ_ONLY;
  endproperty
  a_count_ro: assert property (p_count_ro) else $error("sense count write not refused");
  property p_addr;
    s_get_addr |=> rsp_rdata == $past(node_address) && rsp_status == MAB_ST_OK;
  endproperty
  a_addr: assert property (p_addr) else $error("address read wrong");
  property p_csma_hold;
    $changed(csma_attempts) |-> $past(req_valid && req_set && req_id == 16'h0014);
  endproperty
  a_csma_hold: assert property (p_csma_hold) else $error("attempt count changed unasked");
  property p_csma_range;
    csma_attempts >= 3'h2 && csma_attempts <= 3'h5;
  endproperty
  a_csma_range: assert property (p_csma_range) else $error("attempt count out of range");
  property p_robust;
    cw_exp == 4'h4 |-> cw_lin == 4'h2 && sense_gap_cycles == 24'(6 * MS_CYCLES);
  endproperty
  a_robust: assert property (p_robust) else $error("robust contention set wrong");
  property p_normal;
    cw_exp == 4'h3 |-> cw_lin == 4'h1 && sense_gap_cycles == 24'(3 * MS_CYCLES);
  endproperty
  a_normal: assert property (p_normal) else $error("normal contention set wrong");
  property p_promo;
    promo_grant |-> $past(promo_req) && $past(disconnected);
  endproperty
  a_promo: assert property (p_promo) else $error("grant without request");
  property p_promo_gap;
    promo_grant |=> !promo_grant [*8];
  endproperty
  a_promo_gap: assert property (p_promo_gap) else $error("grants too close");
  property p_retx;
    ctl_sent |=> !ctl_retx_ok;
  endproperty
  a_retx: assert property (p_retx) else $error("retransmit allowed too early");
endmodule // mab_bank_sva
bind mab_bank mab_bank_sva #(.MS_CYCLES(MS_CYCLES)) u_sva (.clk(clk), .arst_n(arst_n),
  .node_address(node_address), .req_valid(req_valid), .req_set(req_set), .req_id(req_id),
  .rsp_valid(rsp_valid), .rsp_status(rsp_status), .rsp_rdata(rsp_rdata), .disconnected(disconnected),
  .promo_req(promo_req), .promo_grant(promo_grant), .ctl_sent(ctl_sent), .ctl_retx_ok(ctl_retx_ok),
  .csma_attempts(csma_attempts), .cw_exp(cw_exp), .cw_lin(cw_lin), .sense_gap_cycles(sense_gap_cycles));
`default_nettype wire

// [bench/testbench.sv]
// Self-checking bench for the attribute bank.
// Drives all ports directly except ctl_ack and child_txn_done, tied low; one-second tick shortened to SEC cycles.
`timescale 1ns/1ps
`default_nettype none
module testbench;
  import mab_pkg::*;
  localparam int SEC = 20;
  localparam int MSC = 40;
  // Arbitrary version code
  localparam logic [7:0] VER = 8'h3C;
  logic clk = 1'b0;
  logic arst_n = 1'b0;
  logic base = 1'b0;
  logic robust = 1'b0;
  logic [47:0] addr = 48'hA5C31E079B42;
  logic req_valid = 1'b0;
  logic req_set = 1'b0;
  logic [15:0] req_id = 16'h0000;
  logic [47:0] req_wdata = 48'h0;
  logic stat_valid = 1'b0;
  logic [15:0] stat_sample = 16'h0000;
  logic disc = 1'b0;
  logic promo_req = 1'b0;
  logic ctl_sent = 1'b0;
  logic cts = 1'b0;
  logic dl_valid = 1'b0;
  logic [15:0] dl = 16'h0000;
  logic rsp_valid, promo_grant, promo_due, band_move, ctl_retx_ok, expired, dl_ok, alive_map;
  logic [1:0] rsp_status, forced_mod;
  logic [47:0] rsp_rdata;
  logic [15:0] stat_avg, route_timeout;
  logic [2:0] csma_attempts, ka_repeats;
  logic [3:0] cw_exp, cw_lin;
  logic [23:0] gap;
  logic [50:0] expq[$];
  logic [50:0] e;
  logic [7:0] cur [MAB_RW_N];
  logic [7:0] v;
  logic [1:0] st, sr;
  int fails = 0;
  int comparisons = 0;
  int span;
  int n_exp = 0;
  mab_bank #(.SEC_CYCLES(SEC), .MS_CYCLES(MSC), .VERSION_CODE(VER)) u_dut (.clk(clk), .arst_n(arst_n),
    .base_node_pin(base), .robust_mode_pin(robust), .node_address(addr), .req_valid(req_valid),
    .req_set(req_set), .req_id(req_id), .req_wdata(req_wdata), .rsp_valid(rsp_valid),
    .rsp_status(rsp_status), .rsp_rdata(rsp_rdata), .stat_valid(stat_valid), .stat_sample(stat_sample),
    .stat_avg(stat_avg), .disconnected(disc), .promo_req(promo_req), .promo_grant(promo_grant),
    .promo_due(promo_due), .band_move(band_move), .ctl_sent(ctl_sent), .ctl_ack(1'b0),
    .ctl_retx_ok(ctl_retx_ok), .child_txn_start(cts), .child_txn_done(1'b0), .child_txn_expired(expired),
    .data_len_valid(dl_valid), .data_len(dl), .data_len_ok(dl_ok), .forced_mod(forced_mod),
    .csma_attempts(csma_attempts), .ka_repeats(ka_repeats), .alive_map(alive_map), .cw_exp(cw_exp),
    .cw_lin(cw_lin), .sense_gap_cycles(gap), .route_timeout(route_timeout));
  always #12.5 clk = ~clk;
  task automatic check(input logic [47:0] got, input logic [47:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      fails++;
      $display("MISMATCH t=%0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic acc(input logic s, input logic [15:0] id, input logic [47:0] d, input logic [1:0] sx,
                     input logic use_d, input logic [47:0] x);
    @(posedge clk);
    req_valid <= 1'b1;
    req_set <= s;
    req_id <= id;
    req_wdata <= d;
    expq.push_back({use_d, sx, x});
    @(posedge clk);
    req_valid <= 1'b0;
  endtask
  task automatic get(input logic [15:0] id, input logic [47:0] x);
    acc(1'b0, id, 48'h0, MAB_ST_OK, 1'b1, x);
  endtask
  task automatic put(input logic [15:0] id, input logic [47:0] d, input logic [1:0] sx);
    acc(1'b1, id, d, sx, 1'b1, 48'h0);
  endtask
  // Pulse one strobe with its data, then sample the registered result
  task automatic pulse(input int kind, input logic [15:0] d);
    @(posedge clk);
    if (kind == 0) dl_valid <= 1'b1; else if (kind == 1) stat_valid <= 1'b1; else promo_req <= 1'b1;
    dl <= d;
    stat_sample <= d;
    @(posedge clk);
    dl_valid <= 1'b0;
    stat_valid <= 1'b0;
    promo_req <= 1'b0;
    #1;
  endtask
  task automatic give_verdict();
    repeat (4) @(posedge clk);
    $display("comparisons %0d fails %0d", comparisons, fails);
    if (fails == 0 && comparisons > 0)
      $display("Result: passed");
    else
      $display("Result: failed");
    $finish;
  endtask
  always @(posedge clk)
    if (expired === 1'b1) n_exp++;
  always @(posedge clk)
  begin
    if (rsp_valid === 1'b1)
    begin
      e = expq.pop_front();
      comparisons++;
      if (rsp_status !== e[49:48] || (e[50] && rsp_rdata !== e[47:0]))
      begin
        fails++;
        $display("MISMATCH t=%0t got %h %h exp %h", $time, rsp_status, rsp_rdata, e);
      end
    end
  end
  initial
  begin
    repeat (20000) @(posedge clk);
    fails++;
    give_verdict();
  end
  initial
  begin
    void'($urandom(32'hB23B78DD));
    repeat (20) @(posedge clk);
    arst_n <= 1'b1;
    for (int i = 0; i < MAB_RW_N; i++) get(MAB_RW_ID[i], 48'(MAB_RW_RST[i]));
    get(MAB_ID_VERSION, 48'(VER));
    get(MAB_ID_SENSE_COUNT, 48'h5);
    get(MAB_ID_HW_ADDR, addr);
    put(MAB_ID_VERSION, 48'h7, MAB_ST_READ_ONLY);
    put(MAB_ID_SENSE_COUNT, 48'h3, MAB_ST_READ_ONLY);
    acc(1'b0, 16'h0002, 48'h0, MAB_ST_UNKNOWN, 1'b0, 48'h0);
    put(16'h0014, 48'h100000003, MAB_ST_RANGE);
    put(MAB_ID_ROUTE_TIMEOUT, 48'h0E11, MAB_ST_RANGE);
    check(48'(route_timeout), 48'(MAB_ROUTE_RST));
    put(MAB_ID_ROUTE_TIMEOUT, 48'h003C, MAB_ST_OK);
    #1;
    check(48'(route_timeout), 48'h3C);
    $display("test defaults done");
    for (int i = 0; i < MAB_RW_N; i++)
    begin
      span = int'(MAB_RW_MAX[i]) - int'(MAB_RW_MIN[i]) + 1;
      v = MAB_RW_MIN[i] + 8'($urandom % span);
      st = MAB_RW_BASE_ONLY[i] ? MAB_ST_READ_ONLY : MAB_ST_OK;
      sr = (st == MAB_ST_OK) ? MAB_ST_RANGE : st;
      put(MAB_RW_ID[i], 48'(v), st);
      cur[i] = (st == MAB_ST_OK) ? v : MAB_RW_RST[i];
      if (MAB_RW_MAX[i] != 8'hFF) put(MAB_RW_ID[i], 48'(MAB_RW_MAX[i]) + 48'h1, sr);
      if (MAB_RW_MIN[i] != 8'h00) put(MAB_RW_ID[i], 48'(MAB_RW_MIN[i]) - 48'h1, sr);
      get(MAB_RW_ID[i], 48'(cur[i]));
    end
    @(posedge clk);
    check(48'(csma_attempts), 48'(cur[MAB_S_CSMA_ATTEMPTS]));
    check(48'(ka_repeats), 48'(cur[MAB_S_KA_REPEATS]));
    check(48'(alive_map), 48'h0);
    check({cw_exp, cw_lin, gap}, {4'h3, 4'h1, 24'(3 * MSC)});
    robust <= 1'b1;
    base <= 1'b1;
    repeat (5) @(posedge clk);
    check({cw_exp, cw_lin, gap}, {4'h4, 4'h2, 24'(6 * MSC)});
    $display("test writes done");
    for (int k = 0; k < 5; k++)
    begin
      put(16'h004A, 48'(k), (k < 4) ? MAB_ST_OK : MAB_ST_RANGE);
      #1;
      check(48'(forced_mod), 48'((k < 4) ? k : 3));
    end
    for (int k = 0; k < 8; k++)
    begin
      put(16'h001D, 48'(k), MAB_ST_OK);
      pulse(0, (k == 0) ? 16'hFFFF : 16'(MAB_SEG_BYTES[k]));
      check(48'(dl_ok), 48'h1);
      if (k > 0) pulse(0, 16'(MAB_SEG_BYTES[k]) + 16'h1);
      if (k > 0) check(48'(dl_ok), 48'h0);
    end
    put(16'h0019, 48'h0, MAB_ST_OK);
    pulse(1, 16'h1000);
    check(48'(stat_avg), 48'h1000);
    put(16'h0019, 48'h1, MAB_ST_OK);
    pulse(1, 16'h3000);
    check(48'(stat_avg), 48'h2000);
    $display("test base node done");
    base <= 1'b0;
    put(16'h0010, 48'h10, MAB_ST_OK);
    put(16'h0015, 48'h2, MAB_ST_OK);
    disc <= 1'b1;
    repeat (10) @(posedge clk);
    pulse(2, 16'h0);
    check(48'(promo_grant), 48'h0);
    repeat (18 * SEC) @(posedge clk);
    pulse(2, 16'h0);
    check(48'(promo_grant), 48'h1);
    pulse(2, 16'h0);
    check(48'(promo_grant), 48'h0);
    ctl_sent <= 1'b1;
    @(posedge clk);
    ctl_sent <= 1'b0;
    repeat (2 * SEC - 1) @(posedge clk);
    check(48'(ctl_retx_ok), 48'h0);
    repeat (SEC + 2) @(posedge clk);
    check(48'(ctl_retx_ok), 48'h1);
    put(16'h0018, 48'h6, MAB_ST_OK);
    cts <= 1'b1;
    @(posedge clk);
    cts <= 1'b0;
    repeat (5 * SEC) @(posedge clk);
    check(48'(n_exp), 48'h0);
    repeat (SEC + 2) @(posedge clk);
    check(48'(n_exp), 48'h1);
    $display("test timers done");
    give_verdict();
  end
endmodule // testbench
`default_nettype wire
